// ===== rtl/osr_switch_ctrl.v
// Purpose: register control of amplifier switches, routing switches, comparator edge flags
// Assumes: inputs synchronous to aclk; AXI4-Lite slave, one write and one read in flight
// Notes: analog switch enables are registered levels, one cycle behind their causes
// Function
// - two-bit trim decodes none, min, medium, max
// - switch closed while its register bit set
// - writing one to clear register opens switch
// - amp0 positive inputs at bits 0,2,3
// - amp1 positive inputs at bits 0,1,4
// - negative pin bit 8, feedback bit 14
// - amp0 mux switch to bus A, amp1 B
// - amp0 to bus zero; amp1 either bus
// - routing from converter, register, fabric; others register
// - mask bit zero forces routing switch open
// - hardware select zero keeps routing switch closed
// - port select bits 6:4, pin 2:0
// - zero port or pin opens under hardware control
// - switch one: fabric high or port1 pin2
// - switch two: single-ended port1 pin3 closes
// - switch three: differential port1 pin2 closes
// - routing states read at status bits 30:28
// - control bit 4 selects comparator mode
// - comparator mode kills compensation and drivers
// - edge detector selects off, rise, fall, both
// - per-comparator flag, write one clears
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "osr_consts.vh"

module osr_switch_ctrl #(
    parameter AW = 8
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address and data
    input wire [AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // converter channel and fabric
    input wire [6:0] converter_channel_config,
    input wire channel_diff_enable,
    input wire [3:2] fabric_sw_ctrl,
    // comparator outputs
    input wire [1:0] comp_out,
    // analog switch enables: one per register bit for the amplifiers, one per routing switch
    output reg [31:0] amp0_switch_en,
    output reg [31:0] amp1_switch_en,
    output reg [2:0] routing_switch_en,
    // amplifier analog controls and comparator edge flags
    output reg [3:0] comp_cap_sel,
    output reg [1:0] comp_mode_en,
    output reg [1:0] drive_stage_en_n,
    output reg [1:0] comparator_irq_flags
);

    // decode of trim code to binary cap enables, gated by comparator mode
    function [1:0] trim_caps;
        input [1:0] code;
        input cmp;
        begin
            if (cmp) begin
                trim_caps = 2'h0;
            end else begin
                case (code)
                    `OSR_TRIM_NONE: trim_caps = 2'h0;
                    `OSR_TRIM_MIN: trim_caps = 2'h1;
                    `OSR_TRIM_MED: trim_caps = 2'h2;
                    default: trim_caps = 2'h3;
                endcase
            end
        end
    endfunction

    // edge event detect for one comparator
    function edge_hit;
        input [1:0] sel;
        input now;
        input was;
        begin
            case (sel)
                `OSR_EDGE_RISE: edge_hit = now & ~was;
                `OSR_EDGE_FALL: edge_hit = ~now & was;
                `OSR_EDGE_BOTH: edge_hit = now ^ was;
                default: edge_hit = 1'b0;
            endcase
        end
    endfunction

    // applies byte strobes to a word
    function [31:0] strb_merge;
        input [31:0] old;
        input [31:0] wd;
        input [3:0] st;
        integer k;
        begin
            strb_merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (st[k]) begin
                    strb_merge[8*k +: 8] = wd[8*k +: 8];
                end
            end
        end
    endfunction

    // registers
    reg [1:0] trim0_ff, trim1_ff;
    reg [31:0] sw0_ff, sw1_ff;
    reg [3:2] hwsel_ff;
    reg [31:0] actl0_ff, actl1_ff;
    reg [1:0] comp_prev_ff;
    reg [AW-1:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    reg aw_have_ff, w_have_ff;

    wire do_write = aw_have_ff & w_have_ff & ~s_axi_bvalid;
    // decode works on the low byte; the address width must be at least eight
    wire [7:0] waddr = awaddr_ff[7:0] & 8'hFC;
    wire [31:0] wmerged_sw0 = strb_merge(sw0_ff, wdata_ff, wstrb_ff);
    wire [31:0] wmerged_sw1 = strb_merge(sw1_ff, wdata_ff, wstrb_ff);
    wire [31:0] clr_bits = strb_merge(32'h00000000, wdata_ff, wstrb_ff);

    // write channel capture: address and data accepted in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            awaddr_ff <= {AW{1'b0}};
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `OSR_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_have_ff & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready <= ~w_have_ff & ~s_axi_wready & ~s_axi_bvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_have_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_have_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (waddr > `OSR_OFF_IRQ) begin
                    s_axi_bresp <= `OSR_RESP_SLVERR;
                end else begin
                    s_axi_bresp <= `OSR_RESP_OKAY;
                end
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // control registers; every write lands at the edge that completes it
    always @(posedge aclk) begin
        if (!aresetn) begin
            trim0_ff <= 2'h0;
            trim1_ff <= 2'h0;
            sw0_ff <= 32'h00000000;
            sw1_ff <= 32'h00000000;
            hwsel_ff <= 2'h0;
            actl0_ff <= 32'h00000000;
            actl1_ff <= 32'h00000000;
        end else if (do_write) begin
            if (waddr == `OSR_OFF_TRIM0) begin
                if (wstrb_ff[0]) trim0_ff <= wdata_ff[1:0];
            end else if (waddr == `OSR_OFF_TRIM1) begin
                if (wstrb_ff[0]) trim1_ff <= wdata_ff[1:0];
            end else if (waddr == `OSR_OFF_SW0) begin
                sw0_ff <= wmerged_sw0 & `OSR_SW_WMASK;
            end else if (waddr == `OSR_OFF_SW1) begin
                sw1_ff <= wmerged_sw1 & `OSR_SW_WMASK;
            end else if (waddr == `OSR_OFF_CLR0) begin
                sw0_ff <= sw0_ff & ~clr_bits;
            end else if (waddr == `OSR_OFF_CLR1) begin
                sw1_ff <= sw1_ff & ~clr_bits;
            end else if (waddr == `OSR_OFF_HWSEL) begin
                if (wstrb_ff[0]) hwsel_ff <= wdata_ff[3:2];
            end else if (waddr == `OSR_OFF_ACTL0) begin
                actl0_ff <= strb_merge(actl0_ff, wdata_ff, wstrb_ff);
            end else if (waddr == `OSR_OFF_ACTL1) begin
                actl1_ff <= strb_merge(actl1_ff, wdata_ff, wstrb_ff);
            end
        end
    end
    // the bus carries one write at a time, so a set and a clear to the same
    // bit cannot collide in one cycle; the chain tests the set offsets before the clears anyway

    // comparator interrupt flags: event set wins over a write-one clear
    wire irq_wr = do_write & (waddr == `OSR_OFF_IRQ) & wstrb_ff[0];
    wire [1:0] irq_clr = irq_wr ? wdata_ff[1:0] : 2'h0;
    wire [1:0] irq_evt;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_edge
            wire [31:0] ctl = (g == 0) ? actl0_ff : actl1_ff;
            assign irq_evt[g] = edge_hit(ctl[`OSR_CTL_EDGE_LO +: 2], comp_out[g],
                                         comp_prev_ff[g]);
        end
    endgenerate

    always @(posedge aclk) begin
        if (!aresetn) begin
            comp_prev_ff <= 2'h0;
            comparator_irq_flags <= 2'h0;
        end else begin
            comp_prev_ff <= comp_out;
            comparator_irq_flags <= (comparator_irq_flags & ~irq_clr) | irq_evt;
        end
    end

    // routing switch logic from converter channel, register bits and fabric
    wire [2:0] ch_port = converter_channel_config[`OSR_CHAN_PORT_LO +: 3];
    wire [2:0] ch_pin = converter_channel_config[`OSR_CHAN_PIN_LO +: 3];
    wire port1 = (ch_port == `OSR_PORT_ONE);
    wire sel_p1p2 = port1 & (ch_pin == `OSR_PIN_TWO);
    wire sel_p1p3 = port1 & (ch_pin == `OSR_PIN_THREE);
    wire zero_sel = (ch_port == 3'h0) | (ch_pin == 3'h0);
    reg [2:0] nxt_route;

    always @* begin
        // switch one: amp0 to converter bus zero
        nxt_route[0] = sw0_ff[`OSR_SW_MASK1] & (~hwsel_ff[`OSR_HW_SW1]
                     | fabric_sw_ctrl[2] | (sel_p1p2 & ~zero_sel));
        // switch two: amp1 to converter bus zero, single-ended path
        nxt_route[1] = sw1_ff[`OSR_SW_MASK23] & (~hwsel_ff[`OSR_HW_SW23]
                     | fabric_sw_ctrl[3]
                     | (~channel_diff_enable & sel_p1p3));
        // switch three: amp1 to converter bus one, differential path
        nxt_route[2] = sw1_ff[`OSR_SW_MASK23] & (~hwsel_ff[`OSR_HW_SW23]
                     | fabric_sw_ctrl[3]
                     | (channel_diff_enable & sel_p1p2));
    end

    // analog outputs registered so every top output comes from a flop
    always @(posedge aclk) begin
        if (!aresetn) begin
            amp0_switch_en <= 32'h00000000;
            amp1_switch_en <= 32'h00000000;
            routing_switch_en <= 3'h0;
            comp_cap_sel <= 4'h0;
            comp_mode_en <= 2'h0;
            drive_stage_en_n <= 2'h3;
        end else begin
            // mux-bus bit 0 goes to bus A on amp0 and bus B on amp1
            amp0_switch_en <= sw0_ff;
            amp1_switch_en <= sw1_ff;
            routing_switch_en <= nxt_route;
            comp_mode_en <= {actl1_ff[`OSR_CTL_CMP], actl0_ff[`OSR_CTL_CMP]};
            comp_cap_sel <= {trim_caps(trim1_ff, actl1_ff[`OSR_CTL_CMP]),
                             trim_caps(trim0_ff, actl0_ff[`OSR_CTL_CMP])};
            // high level shuts both output stages of that amplifier
            drive_stage_en_n <= {actl1_ff[`OSR_CTL_CMP], actl0_ff[`OSR_CTL_CMP]};
        end
    end

    // read channel
    reg [31:0] rd_word;
    reg rd_ok;
    wire [7:0] raddr = s_axi_araddr[7:0] & 8'hFC;
    always @* begin
        rd_word = 32'h00000000;
        rd_ok = 1'b1;
        if (raddr == `OSR_OFF_TRIM0) begin
            rd_word[1:0] = trim0_ff;
        end else if (raddr == `OSR_OFF_TRIM1) begin
            rd_word[1:0] = trim1_ff;
        end else if (raddr == `OSR_OFF_SW0) begin
            rd_word = sw0_ff;
        end else if (raddr == `OSR_OFF_SW1) begin
            rd_word = sw1_ff;
        end else if (raddr == `OSR_OFF_CLR0 || raddr == `OSR_OFF_CLR1) begin
            rd_word = 32'h00000000; // write-only strobes read zero
        end else if (raddr == `OSR_OFF_HWSEL) begin
            rd_word[3:2] = hwsel_ff;
        end else if (raddr == `OSR_OFF_STAT) begin
            rd_word[`OSR_STAT_LO +: 3] = routing_switch_en;
        end else if (raddr == `OSR_OFF_ACTL0) begin
            rd_word = actl0_ff;
        end else if (raddr == `OSR_OFF_ACTL1) begin
            rd_word = actl1_ff;
        end else if (raddr == `OSR_OFF_IRQ) begin
            rd_word[1:0] = comparator_irq_flags;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // one read in flight: arready pulses, data follows next cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `OSR_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? `OSR_RESP_OKAY : `OSR_RESP_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // osr_switch_ctrl

// ===== rtl/osr_consts.vh
// Purpose: constants for the amplifier-block switch routing control
// Assumes: AXI4-Lite byte addresses, 32-bit words
// Notes: offsets are locally assigned
`ifndef OSR_CONSTS_VH
`define OSR_CONSTS_VH
// register byte offsets
`define OSR_OFF_TRIM0 8'h00
`define OSR_OFF_TRIM1 8'h04
`define OSR_OFF_SW0 8'h08
`define OSR_OFF_SW1 8'h0C
`define OSR_OFF_CLR0 8'h10
`define OSR_OFF_CLR1 8'h14
`define OSR_OFF_HWSEL 8'h18
`define OSR_OFF_STAT 8'h1C
`define OSR_OFF_ACTL0 8'h20
`define OSR_OFF_ACTL1 8'h24
`define OSR_OFF_IRQ 8'h28
// switch register field positions
`define OSR_SW_MUXBUS 0
`define OSR_SW_PINA 1
`define OSR_SW_PINB 2
`define OSR_SW_PINC 3
`define OSR_SW_PIND 4
`define OSR_SW_NEG 8
`define OSR_SW_FB 14
`define OSR_SW_MASK1 18
`define OSR_SW_MASK23 19
`define OSR_SW_WMASK 32'h000C411F
// hardware select, status, control fields
`define OSR_HW_SW1 2
`define OSR_HW_SW23 3
`define OSR_STAT_LO 28
`define OSR_CTL_CMP 4
`define OSR_CTL_EDGE_LO 8
`define OSR_CHAN_PORT_LO 4
`define OSR_CHAN_PIN_LO 0
// edge selection codes
`define OSR_EDGE_OFF 2'h0
`define OSR_EDGE_RISE 2'h1
`define OSR_EDGE_FALL 2'h2
`define OSR_EDGE_BOTH 2'h3
// trim codes
`define OSR_TRIM_NONE 2'h0
`define OSR_TRIM_MIN 2'h1
`define OSR_TRIM_MED 2'h2
`define OSR_TRIM_MAX 2'h3
// channel address values that close routing switches
`define OSR_PORT_ONE 3'h1
`define OSR_PIN_TWO 3'h2
`define OSR_PIN_THREE 3'h3
// bus responses
`define OSR_RESP_OKAY 2'h0
`define OSR_RESP_SLVERR 2'h2
`endif

// ===== tb/osr_switch_ctrl_sva.sv
// Purpose: port checks for the switch routing control
// Assumes: one aclk domain, aresetn synchronous active low
// Notes: analog enables lag their causes by one edge
`timescale 1ns/10ps
module osr_switch_ctrl_sva (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // bus handshakes
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    // fabric and analog controls
    input wire [3:2] fabric_sw_ctrl,
    input wire [31:0] amp0_switch_en,
    input wire [31:0] amp1_switch_en,
    input wire [2:0] routing_switch_en,
    input wire [3:0] comp_cap_sel,
    input wire [1:0] comp_mode_en,
    input wire [1:0] drive_stage_en_n
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // a cleared mask wins over every other control input
    chk_mask_one: assert property (!amp0_switch_en[18] |-> !routing_switch_en[0])
        else $error("switch one closed while masked");
    chk_mask_two_three: assert property (!amp1_switch_en[19] |-> routing_switch_en[2:1] == 2'h0)
        else $error("switch two or three closed while masked");
    // fabric high closes the switch one edge later
    chk_fabric_one: assert property (amp0_switch_en[18] && $past(fabric_sw_ctrl[2])
        |-> routing_switch_en[0])
        else $error("fabric did not close switch one");
    chk_fabric_two_three: assert property (amp1_switch_en[19] && $past(fabric_sw_ctrl[3])
        |-> routing_switch_en[2:1] == 2'h3)
        else $error("fabric did not close switches two and three");
    // comparator mode overrides trim and drive settings
    chk_cmp_mode_zero: assert property (comp_mode_en[0]
        |-> comp_cap_sel[1:0] == 2'h0 && drive_stage_en_n[0])
        else $error("amp0 comparator mode left trim or drive on");
    chk_cmp_mode_one: assert property (comp_mode_en[1]
        |-> comp_cap_sel[3:2] == 2'h0 && drive_stage_en_n[1])
        else $error("amp1 comparator mode left trim or drive on");
    // bus answers come in a bounded time
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_write_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
        else $error("write response late");
    chk_resp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after acceptance");
    cover property (routing_switch_en[0]);
    cover property (comp_mode_en == 2'h3);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule // osr_switch_ctrl_sva

// ===== tb/osr_chan_model.sv
// Purpose: converter sequencer and fabric levels seen by the block
// Assumes: bench commands each step just after an edge
// Notes: levels change only after an edge, never mid-cycle
`timescale 1ns/10ps
module osr_chan_model (
    // clock
    input wire aclk,
    // next step commanded by the bench
    input wire [11:0] step,
    // channel, fabric and comparator levels
    output reg [6:0] converter_channel_config = 7'h00,
    output reg channel_diff_enable = 1'b0,
    output reg [3:2] fabric_sw_ctrl = 2'h0,
    output reg [1:0] comp_out = 2'h0
);
    // registered so the block never sees a change inside its own edge
    always @(posedge aclk) begin
        {comp_out, fabric_sw_ctrl, channel_diff_enable, converter_channel_config} <= step;
    end
endmodule // osr_chan_model

// ===== tb/osr_switch_ctrl_tb.sv
// Purpose: self-checking bench for the switch routing control
// Assumes: bus answers within 100 cycles
// Notes: reads are checked by the monitor from a queue of expected words
`timescale 1ns/10ps
`include "osr_consts.vh"
module osr_switch_ctrl_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp, comp_out, comp_mode_en, drive_stage_en_n, comparator_irq_flags;
    wire [31:0] s_axi_rdata, amp0_switch_en, amp1_switch_en;
    wire [6:0] converter_channel_config;
    wire channel_diff_enable;
    wire [3:2] fabric_sw_ctrl;
    wire [2:0] routing_switch_en;
    wire [3:0] comp_cap_sel;
    logic [11:0] step = 12'h0, c;
    logic [33:0] exp_q[$];
    logic [31:0] v, w;
    logic [7:0] rnd = 8'h23;
    logic [2:0] r;
    int error_cnt = 0, comparisons = 0, i;
    osr_switch_ctrl osr_switch_ctrl_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .converter_channel_config,
        .channel_diff_enable, .fabric_sw_ctrl, .comp_out, .amp0_switch_en, .amp1_switch_en,
        .routing_switch_en, .comp_cap_sel, .comp_mode_en, .drive_stage_en_n, .comparator_irq_flags);
    osr_chan_model osr_chan_model_inst (.aclk, .step, .converter_channel_config,
        .channel_diff_enable, .fabric_sw_ctrl, .comp_out);
    // clock
    always #5 aclk = ~aclk;
    function automatic logic [31:0] rand32();
        logic [31:0] x;
        repeat (4) begin
            rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
            x = {x[23:0], rnd};
        end
        return x;
    endfunction
    // expected routing: mask, then hardware select, fabric or channel match
    function automatic logic [2:0] route(input logic m1, m23, h2, h3, input logic [11:0] s);
        logic p12, p13;
        p12 = s[6:4] == 3'h1 && s[2:0] == 3'h2;
        p13 = s[6:4] == 3'h1 && s[2:0] == 3'h3;
        return {m23 & (!h3 | s[9] | (s[7] & p12)), m23 & (!h3 | s[9] | (!s[7] & p13)),
            m1 & (!h2 | s[8] | p12)};
    endfunction
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        if (n >= 100) error_cnt++;
        s_axi_bready <= 1'b0;
        // let one edge pass so the next call never re-raises bready at once
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int n;
        n = 0;
        exp_q.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        if (n >= 100) error_cnt++;
        s_axi_rready <= 1'b0;
        // the monitor takes the answer at that edge before anything moves on
        @(posedge aclk);
    endtask
    // let registered outputs land before looking at them
    task automatic settle();
        repeat (3) @(posedge aclk);
    endtask
    task automatic test_done();
        $display("counts: %0d compared, %0d bad", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // monitor pairs each read answer with the oldest expectation
    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && exp_q.size() > 0) begin
            check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        end
    end
    // watchdog, far beyond the several hundred cycles the tests need
    initial begin
        #400000;
        error_cnt++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`OSR_OFF_SW0, 34'h0);
        rd(`OSR_OFF_STAT, 34'h0);
        // drive shutdown leaves its reset level once comparator mode reads off
        check({29'h0, routing_switch_en, drive_stage_en_n}, 34'h0);
        $display("test reset done");
        for (i = 0; i < 2; i++) begin
            v = rand32();
            v = v & 32'h000C4001; // at most one switch per input path
            w = rand32();
            wr(8'(`OSR_OFF_SW0 + 4 * i), v);
            rd(8'(`OSR_OFF_SW0 + 4 * i), {2'h0, v & `OSR_SW_WMASK});
            wr(8'(`OSR_OFF_CLR0 + 4 * i), w);
            rd(8'(`OSR_OFF_SW0 + 4 * i), {2'h0, v & ~w & `OSR_SW_WMASK});
            settle();
            check({2'h0, i ? amp1_switch_en : amp0_switch_en}, {2'h0, v & ~w & `OSR_SW_WMASK});
        end
        $display("test switch set and clear done");
        for (i = 0; i < 4; i++) begin
            wr(`OSR_OFF_TRIM0, 32'(i));
            wr(`OSR_OFF_TRIM1, 32'(i ^ 1));
            rd(`OSR_OFF_TRIM1, {2'h0, 32'(i ^ 1)});
            check({30'h0, comp_cap_sel}, {30'h0, 2'(i ^ 1), 2'(i)});
        end
        $display("test trim done");
        for (i = 0; i < 24; i++) begin
            v = rand32();
            c = v[11:0];
            if (v[12]) c[6:0] = {4'h1, v[13] ? 3'h2 : 3'h3};
            step <= {2'h0, c[9:0]};
            wr(`OSR_OFF_SW0, {13'h0, v[18], 18'h0});
            wr(`OSR_OFF_SW1, {12'h0, v[19], 19'h0});
            wr(`OSR_OFF_HWSEL, {28'h0, v[15:14], 2'h0});
            r = route(v[18], v[19], v[14], v[15], {2'h0, c[9:0]});
            rd(`OSR_OFF_STAT, {3'h0, r, 28'h0});
            check({31'h0, routing_switch_en}, {31'h0, r});
        end
        $display("test routing done");
        wr(`OSR_OFF_ACTL0, 32'h10);
        wr(`OSR_OFF_ACTL1, 32'h10);
        rd(`OSR_OFF_ACTL1, 34'h10);
        settle();
        check({26'h0, comp_mode_en, drive_stage_en_n, comp_cap_sel}, 34'hF0);
        wr(`OSR_OFF_ACTL0, 32'h0);
        wr(`OSR_OFF_ACTL1, 32'h0);
        settle();
        check({30'h0, comp_cap_sel}, 34'hB);
        $display("test comparator mode done");
        for (i = 0; i < 4; i++) begin
            wr(`OSR_OFF_ACTL0, {22'h0, 2'(i), 8'h00});
            step <= 12'h400;
            settle();
            rd(`OSR_OFF_IRQ, {33'h0, i[0]});
            wr(`OSR_OFF_IRQ, 32'h3);
            rd(`OSR_OFF_IRQ, 34'h0);
            step <= 12'h000;
            settle();
            rd(`OSR_OFF_IRQ, {33'h0, i[1]});
            wr(`OSR_OFF_IRQ, 32'h3);
        end
        rd(8'h2C, {`OSR_RESP_SLVERR, 32'h0});
        $display("test edges and unmapped done");
        test_done();
    end
endmodule // osr_switch_ctrl_tb
bind osr_switch_ctrl osr_switch_ctrl_sva osr_switch_ctrl_sva_inst (.aclk, .aresetn,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .fabric_sw_ctrl, .amp0_switch_en, .amp1_switch_en, .routing_switch_en,
    .comp_cap_sel, .comp_mode_en, .drive_stage_en_n);
